// >>> shared/ovc_params.svh
`ifndef OVC_PARAMS_SVH
`define OVC_PARAMS_SVH
// register indices, byte address is index times four
`define OVC_IDX_W 10
`define OVC_IDX_OVT 10'h009
`define OVC_IDX_UVT 10'h00A
`define OVC_IDX_EXU 10'h00C
`define OVC_IDX_EXL 10'h00D
`define OVC_IDX_CTRL 10'h32C
`define OVC_IDX_STAT 10'h340
`define OVC_IDX_MASK 10'h341
`define OVC_IDX_SCAN 10'h342
// fields and reset values
`define OVC_CODE_W 6
`define OVC_OVT_RST 6'h3F
`define OVC_UVT_RST 6'h00
`define OVC_EXC_RST 8'h00
`define OVC_MODE_LSB 0
`define OVC_GO_BIT 2
`define OVC_LOCK_LSB 3
`define OVC_STAT_W 5
`define OVC_STAT_RST 5'h00
`define OVC_STAT_OV 0
`define OVC_STAT_UV 1
`define OVC_STAT_BDONE 2
`define OVC_STAT_BFAIL 3
`define OVC_STAT_START 4
// threshold decode, millivolts
`define OVC_MV_W 13
`define OVC_OV_LO0 6'h02
`define OVC_OV_HI0 6'h0E
`define OVC_OV_LO1 6'h12
`define OVC_OV_HI1 6'h1E
`define OVC_OV_LO2 6'h22
`define OVC_OV_HI2 6'h2E
`define OVC_OV_MV0 13'h0A8C
`define OVC_OV_MV1 13'h0DAC
`define OVC_OV_MV2 13'h104F
`define OVC_OV_STEP 13'h0019
`define OVC_UV_MV0 13'h04B0
`define OVC_UV_STEP 13'h0032
`define OVC_UV_TOP_CODE 6'h26
`define OVC_UV_TOP_MV 13'h0C1C
// channel dwell, a least time rounded up to clock cycles
`define OVC_CLK_NS 32'h00000028
`define OVC_DWELL_NS 32'h000003E8
`define OVC_DWELL_CYC ((`OVC_DWELL_NS + `OVC_CLK_NS - 32'h1) / `OVC_CLK_NS)
`endif

// >>> shared/ovc_pkg.sv
`default_nettype none
package ovc_pkg;
  typedef enum logic [1:0] {
    OVC_MODE_IDLE = 2'h0,
    OVC_MODE_RR = 2'h1,
    OVC_MODE_BUILT_IN_SELF_TEST = 2'h2,
    OVC_MODE_LOCK = 2'h3
  } ovc_mode_t;
  typedef enum logic [3:0] {
    OVC_S_IDLE = 4'h1,
    OVC_S_RUN = 4'h2,
    OVC_S_BIST1 = 4'h4,
    OVC_S_BIST2 = 4'h8
  } ovc_state_t;
endpackage : ovc_pkg
`default_nettype wire

// >>> shared/ovc_scan_if.sv
`timescale 1ns/1ns
`default_nettype none
`include "ovc_params.svh"
interface ovc_scan_if;
  logic start;
  ovc_pkg::ovc_mode_t mode;
  logic [3:0] lock_ch;
  logic [`OVC_MV_W-1:0] ov_mv;
  logic [`OVC_MV_W-1:0] uv_mv;
  logic [`OVC_MV_W-1:0] sense_mv;
  logic [15:0] excl;
  logic [3:0] sel_ch;
  logic [3:0] hit_ch;
  logic ov_hit;
  logic uv_hit;
  logic built_in_self_test_done;
  logic built_in_self_test_fail;
  logic running;
  modport ctrl (output start, mode, lock_ch, ov_mv, uv_mv, sense_mv, excl,
    input sel_ch, hit_ch, ov_hit, uv_hit, built_in_self_test_done, built_in_self_test_fail, running);
  modport scan (input start, mode, lock_ch, ov_mv, uv_mv, sense_mv, excl,
    output sel_ch, hit_ch, ov_hit, uv_hit, built_in_self_test_done, built_in_self_test_fail, running);
endinterface : ovc_scan_if
`default_nettype wire

// >>> src/ovc_ctrl.sv
// Function
// - overvoltage code is bits 5:0 of its register, resets to all ones
// - overvoltage codes 0x02..0x0E give 2700..3000 mV in 25 mV steps
// - overvoltage codes 0x12..0x1E give 3500..3800 mV in 25 mV steps
// - overvoltage codes 0x22..0x2E give 4175..4475 mV in 25 mV steps
// - any other overvoltage code selects 2700 mV
// - undervoltage codes 0x00..0x26 give 1200..3100 mV in 50 mV steps, reset zero
// - undervoltage codes above the range select 3100 mV
// - one exclusion bit per channel, 16..9 upper register, 8..1 lower register
// - an excluded channel never raises an undervoltage detection
// - start bit samples all settings, starts comparators, then reads zero
// - mode 00 keeps comparators idle, mode 01 scans all channels in turn
// - mode 10 runs the comparator self-test cycle
// - mode 11 holds both comparators on the locked channel
// - lock field value n selects sense channel n+1
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ovc_params.svh"
module ovc_ctrl #(
  parameter int unsigned DWELL_CYC = `OVC_DWELL_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`OVC_MV_W-1:0] sense_mv,
  output logic [3:0] sense_sel,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic rst_s1;
  logic rst_n;
  logic [`OVC_CODE_W-1:0] ovt;
  logic [`OVC_CODE_W-1:0] uvt;
  logic [7:0] exu;
  logic [7:0] exl;
  logic [3:0] lock_f;
  ovc_pkg::ovc_mode_t mode_f;
  logic go;
  logic [`OVC_STAT_W-1:0] status;
  logic [`OVC_STAT_W-1:0] mask;
  logic [`OVC_STAT_W-1:0] next_status;
  logic [`OVC_STAT_W-1:0] ev;
  logic [3:0] last_ch;
  logic [`OVC_MV_W-1:0] dec_ov;
  logic [`OVC_MV_W-1:0] dec_uv;
  logic [31:0] next_rdata;
  logic next_err;
  logic setup;
  logic wr;
  logic wr_go;
  logic [`OVC_IDX_W-1:0] idx;
  ovc_pkg::ovc_mode_t mode_q;
  logic [3:0] lock_q;
  ovc_scan_if sif ();

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, no wait states
  assign idx = paddr[11:2];
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign wr_go = wr && idx == `OVC_IDX_CTRL && pwdata[`OVC_GO_BIT];

  always_comb
  begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (idx)
      `OVC_IDX_OVT: next_rdata = {26'h0000000, ovt};
      `OVC_IDX_UVT: next_rdata = {26'h0000000, uvt};
      `OVC_IDX_EXU: next_rdata = {24'h000000, exu};
      `OVC_IDX_EXL: next_rdata = {24'h000000, exl};
      `OVC_IDX_CTRL: next_rdata = {25'h0000000, lock_f, go, mode_f};
      `OVC_IDX_STAT: next_rdata = {27'h0000000, status};
      `OVC_IDX_MASK: next_rdata = {27'h0000000, mask};
      `OVC_IDX_SCAN: next_rdata = {21'h000000, mode_q, sif.running, last_ch, sif.sel_ch};
      default: next_err = 1'b1;
    endcase
    if (paddr[1:0] != 2'h0)
      next_err = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (ce)
    begin
      pready <= setup;
      pslverr <= setup && next_err;
      if (setup)
        prdata <= pwrite ? 32'h00000000 : next_rdata;
    end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      ovt <= `OVC_OVT_RST;
      uvt <= `OVC_UVT_RST;
      exu <= `OVC_EXC_RST;
      exl <= `OVC_EXC_RST;
    end
    else if (ce && wr)
    begin
      if (idx == `OVC_IDX_OVT)
        ovt <= pwdata[`OVC_CODE_W-1:0];
      if (idx == `OVC_IDX_UVT)
        uvt <= pwdata[`OVC_CODE_W-1:0];
      if (idx == `OVC_IDX_EXU)
        exu <= pwdata[7:0];
      if (idx == `OVC_IDX_EXL)
        exl <= pwdata[7:0];
    end

  // reserved control bits are not stored and read zero
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      lock_f <= 4'h0;
      mode_f <= ovc_pkg::OVC_MODE_IDLE;
    end
    else if (ce && wr && idx == `OVC_IDX_CTRL)
    begin
      lock_f <= pwdata[`OVC_LOCK_LSB +: 4];
      mode_f <= ovc_pkg::ovc_mode_t'(pwdata[`OVC_MODE_LSB +: 2]);
    end

  // start bit: high for one cycle, then clears itself
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      go <= 1'b0;
    else if (ce)
      go <= wr_go;

  ////////////////////////////////////////////////////////////////////////////
  // sampled settings, held until the next start
  ovc_thr_dec u_dec (
    .ov_code(ovt),
    .uv_code(uvt),
    .ov_mv(dec_ov),
    .uv_mv(dec_uv)
  );

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      mode_q <= ovc_pkg::OVC_MODE_IDLE;
      lock_q <= 4'h0;
      sif.ov_mv <= `OVC_OV_MV0;
      sif.uv_mv <= `OVC_UV_MV0;
      sif.excl <= {`OVC_EXC_RST, `OVC_EXC_RST};
    end
    else if (ce && wr_go)
    begin
      mode_q <= ovc_pkg::ovc_mode_t'(pwdata[`OVC_MODE_LSB +: 2]);
      lock_q <= pwdata[`OVC_LOCK_LSB +: 4];
      sif.ov_mv <= dec_ov;
      sif.uv_mv <= dec_uv;
      sif.excl <= {exu, exl};
    end

  assign sif.start = go;
  assign sif.mode = mode_q;
  assign sif.lock_ch = lock_q;
  assign sif.sense_mv = sense_mv;

  ovc_scan #(
    .DWELL_CYC(DWELL_CYC)
  ) u_scan (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .sif(sif)
  );

  assign sense_sel = sif.sel_ch;

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear, a set wins over a clear
  assign ev[`OVC_STAT_OV] = sif.ov_hit;
  assign ev[`OVC_STAT_UV] = sif.uv_hit;
  assign ev[`OVC_STAT_BDONE] = sif.built_in_self_test_done;
  assign ev[`OVC_STAT_BFAIL] = sif.built_in_self_test_done && sif.built_in_self_test_fail;
  assign ev[`OVC_STAT_START] = go;

  always_comb
  begin
    next_status = status;
    if (wr && idx == `OVC_IDX_STAT)
      next_status = status & ~pwdata[`OVC_STAT_W-1:0];
    next_status = next_status | ev;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      status <= `OVC_STAT_RST;
    else if (ce)
      status <= next_status;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      mask <= `OVC_STAT_RST;
    else if (ce && wr && idx == `OVC_IDX_MASK)
      mask <= pwdata[`OVC_STAT_W-1:0];

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      last_ch <= 4'h0;
    else if (ce && (sif.ov_hit || sif.uv_hit))
      last_ch <= sif.hit_ch;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      irq <= 1'b0;
    else if (ce)
      irq <= |(status & mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_ovt_reset_ones: assert property ($rose(rst_n) |-> ovt == `OVC_OVT_RST)
    else $error("overvoltage code not all ones after reset");
  a_ov_low_range: assert property (wr_go && ovt >= `OVC_OV_LO0 && ovt <= `OVC_OV_HI0 |=>
    sif.ov_mv == 13'(13'h0A8C + 13'($past(ovt) - 6'h02) * 13'h0019))
    else $error("low overvoltage range decoded wrong");
  a_ov_mid_range: assert property (wr_go && ovt == `OVC_OV_HI1 |=> sif.ov_mv == 13'h0ED8)
    else $error("middle overvoltage range decoded wrong");
  a_ov_high_range: assert property (wr_go && ovt == `OVC_OV_LO2 |=> sif.ov_mv == 13'h104F)
    else $error("high overvoltage range decoded wrong");
  a_ov_out_range: assert property (wr_go && (ovt < `OVC_OV_LO0 || ovt == 6'h3F) |=>
    sif.ov_mv == 13'h0A8C)
    else $error("undefined overvoltage code not 2700 mV");
  a_uv_decode_val: assert property (wr_go |=> sif.uv_mv == (($past(uvt) > 6'h26) ? 13'h0C1C :
    13'(13'h04B0 + 13'($past(uvt)) * 13'h0032)))
    else $error("undervoltage code decoded wrong");
  a_uv_excluded_ch: assert property (sif.uv_hit |-> !$past(sif.excl[sif.sel_ch]))
    else $error("undervoltage reported on excluded channel");
  a_go_self_clear: assert property (wr_go |=> go ##1 !go)
    else $error("start bit did not clear after one cycle");
  a_idle_no_hits: assert property (mode_q == ovc_pkg::OVC_MODE_IDLE && !go |->
    ##1 !sif.ov_hit && !sif.uv_hit)
    else $error("detection while idle");
  a_lock_holds_ch: assert property (mode_q == ovc_pkg::OVC_MODE_LOCK && $past(go) |->
    sense_sel == lock_q)
    else $error("locked mode left its channel");
  a_built_in_self_test_finishes: assert property (go && ce && mode_q == ovc_pkg::OVC_MODE_BUILT_IN_SELF_TEST |->
    ##[1:1000] sif.built_in_self_test_done)
    else $error("self-test did not finish");
  a_rr_advances: assert property (mode_q == ovc_pkg::OVC_MODE_RR && sif.running && ce &&
    !$past(go) && $changed(sense_sel) |-> sense_sel == 4'($past(sense_sel) + 4'h1))
    else $error("round robin skipped a channel");
endmodule : ovc_ctrl
`default_nettype wire

// >>> src/ovc_scan.sv
`timescale 1ns/1ns
`default_nettype none
`include "ovc_params.svh"
module ovc_scan #(
  parameter int unsigned DWELL_CYC = `OVC_DWELL_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  ovc_scan_if.scan sif
);
  if (DWELL_CYC < 2 || DWELL_CYC > 65535)
  begin : g_bad_dwell
    $error("dwell count out of range");
  end

  ovc_pkg::ovc_state_t state;
  logic [15:0] cnt;
  logic [3:0] ch;
  logic tick;
  logic [1:0] c_ch;
  logic [1:0] c_ovp;
  logic [1:0] c_ov;
  logic [1:0] c_uvm;
  logic [1:0] c_uv;

  // {above overvoltage, below undervoltage and not excluded}
  function automatic logic [1:0] cmp(input logic [`OVC_MV_W-1:0] v,
    input logic [`OVC_MV_W-1:0] ov, input logic [`OVC_MV_W-1:0] uv, input logic ex);
    cmp = {v > ov, (v < uv) && !ex};
  endfunction : cmp

  assign tick = (state != ovc_pkg::OVC_S_IDLE) && (cnt == 16'(DWELL_CYC - 1));
  assign c_ch = cmp(sif.sense_mv, sif.ov_mv, sif.uv_mv, sif.excl[ch]);
  assign c_ovp = cmp(sif.ov_mv + 13'h0001, sif.ov_mv, sif.uv_mv, 1'b1);
  assign c_ov = cmp(sif.ov_mv, sif.ov_mv, sif.uv_mv, 1'b1);
  assign c_uvm = cmp(sif.uv_mv - 13'h0001, sif.ov_mv, sif.uv_mv, 1'b0);
  assign c_uv = cmp(sif.uv_mv, sif.ov_mv, sif.uv_mv, 1'b0);
  assign sif.running = (state != ovc_pkg::OVC_S_IDLE);
  assign sif.sel_ch = ch;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      state <= ovc_pkg::OVC_S_IDLE;
    else if (ce)
    begin
      if (sif.start)
        case (sif.mode)
          ovc_pkg::OVC_MODE_RR: state <= ovc_pkg::OVC_S_RUN;
          ovc_pkg::OVC_MODE_LOCK: state <= ovc_pkg::OVC_S_RUN;
          ovc_pkg::OVC_MODE_BUILT_IN_SELF_TEST: state <= ovc_pkg::OVC_S_BIST1;
          default: state <= ovc_pkg::OVC_S_IDLE;
        endcase
      else if (tick)
        case (state)
          ovc_pkg::OVC_S_BIST1: state <= ovc_pkg::OVC_S_BIST2;
          ovc_pkg::OVC_S_BIST2: state <= ovc_pkg::OVC_S_IDLE;
          default: state <= state;
        endcase
    end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      cnt <= 16'h0000;
    else if (ce)
      cnt <= (sif.start || tick || !sif.running) ? 16'h0000 : cnt + 16'h0001;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      ch <= 4'h0;
    else if (ce)
    begin
      if (sif.start)
        ch <= (sif.mode == ovc_pkg::OVC_MODE_LOCK) ? sif.lock_ch : 4'h0;
      else if (tick && state == ovc_pkg::OVC_S_RUN && sif.mode == ovc_pkg::OVC_MODE_RR)
        ch <= ch + 4'h1;
    end

  // detections only at the end of a dwell in a running mode
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      sif.ov_hit <= 1'b0;
      sif.uv_hit <= 1'b0;
      sif.hit_ch <= 4'h0;
    end
    else if (ce)
    begin
      sif.ov_hit <= tick && state == ovc_pkg::OVC_S_RUN && c_ch[1];
      sif.uv_hit <= tick && state == ovc_pkg::OVC_S_RUN && c_ch[0];
      sif.hit_ch <= ch;
    end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      sif.built_in_self_test_done <= 1'b0;
      sif.built_in_self_test_fail <= 1'b0;
    end
    else if (ce)
    begin
      sif.built_in_self_test_done <= tick && state == ovc_pkg::OVC_S_BIST2;
      if (sif.start)
        sif.built_in_self_test_fail <= 1'b0;
      else if (tick && state == ovc_pkg::OVC_S_BIST1)
        sif.built_in_self_test_fail <= !(c_ovp[1] && !c_ov[1]);
      else if (tick && state == ovc_pkg::OVC_S_BIST2)
        sif.built_in_self_test_fail <= sif.built_in_self_test_fail || !(c_uvm[0] && !c_uv[0]);
    end
endmodule : ovc_scan
`default_nettype wire

// >>> src/ovc_thr_dec.sv
`timescale 1ns/1ns
`default_nettype none
`include "ovc_params.svh"
module ovc_thr_dec (
  input wire logic [`OVC_CODE_W-1:0] ov_code,
  input wire logic [`OVC_CODE_W-1:0] uv_code,
  output logic [`OVC_MV_W-1:0] ov_mv,
  output logic [`OVC_MV_W-1:0] uv_mv
);
  always_comb
  begin
    ov_mv = `OVC_OV_MV0;
    if (ov_code >= `OVC_OV_LO0 && ov_code <= `OVC_OV_HI0)
      ov_mv = `OVC_OV_MV0 + `OVC_MV_W'(`OVC_MV_W'(ov_code - `OVC_OV_LO0) * `OVC_OV_STEP);
    if (ov_code >= `OVC_OV_LO1 && ov_code <= `OVC_OV_HI1)
      ov_mv = `OVC_OV_MV1 + `OVC_MV_W'(`OVC_MV_W'(ov_code - `OVC_OV_LO1) * `OVC_OV_STEP);
    if (ov_code >= `OVC_OV_LO2 && ov_code <= `OVC_OV_HI2)
      ov_mv = `OVC_OV_MV2 + `OVC_MV_W'(`OVC_MV_W'(ov_code - `OVC_OV_LO2) * `OVC_OV_STEP);
  end

  always_comb
  begin
    uv_mv = `OVC_UV_TOP_MV;
    if (uv_code <= `OVC_UV_TOP_CODE)
      uv_mv = `OVC_UV_MV0 + `OVC_MV_W'(`OVC_MV_W'(uv_code) * `OVC_UV_STEP);
  end
endmodule : ovc_thr_dec
`default_nettype wire

// >>> verif/ovc_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int DW = 3;
  logic clk_sys;
  logic nrst;
  logic ce;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic er;
  logic irq;
  logic clr;
  logic [12:0] sense_mv;
  logic [3:0] sense_sel;
  logic [15:0] seen;
  int n_errors;
  int check_count;
  logic [11:0] ra [7] = '{12'h024, 12'h028, 12'h030, 12'h034, 12'hCB0, 12'hD00, 12'hD04};
  logic [31:0] rv [7] = '{32'h3F, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [5:0] oc [10] = '{6'h00, 6'h02, 6'h08, 6'h0E, 6'h0F, 6'h12, 6'h1E, 6'h22, 6'h2E, 6'h3F};
  logic [5:0] uc [5] = '{6'h00, 6'h10, 6'h26, 6'h27, 6'h3F};

  ovc_ctrl #(.DWELL_CYC(DW)) dut (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sense_mv(sense_mv),
    .sense_sel(sense_sel),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // channels visited since last clear
  always @(posedge clk_sys)
  begin
    if (clr)
      seen <= 16'h0000;
    else
      seen <= seen | (16'h0001 << sense_sel);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic [31:0] sv, input logic [31:0] ev);
    check_count++;
    if (sv !== ev)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, ev, sv);
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      n_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [12:0] ov_mv(input logic [5:0] c);
    if (c >= 6'h02 && c <= 6'h0E)
      return 13'hA8C + 13'h019 * (c - 6'h02);
    if (c >= 6'h12 && c <= 6'h1E)
      return 13'hDAC + 13'h019 * (c - 6'h12);
    if (c >= 6'h22 && c <= 6'h2E)
      return 13'h104F + 13'h019 * (c - 6'h22);
    return 13'hA8C;
  endfunction : ov_mv

  function automatic logic [12:0] uv_mv(input logic [5:0] c);
    return (c <= 6'h26) ? 13'h4B0 + 13'h032 * c : 13'hC1C;
  endfunction : uv_mv

  // locked on channel 1, then stopped; detections read back and cleared
  task run(input logic [5:0] ovc, input logic [5:0] uvc, input logic [12:0] s,
    input logic [1:0] ev);
    apb(1'b1, 12'h024, {26'h0, ovc});
    apb(1'b1, 12'h028, {26'h0, uvc});
    sense_mv <= s;
    apb(1'b1, 12'hCB0, 32'h07);
    repeat (4 * DW + 4) @(posedge clk_sys);
    chk("sense_sel", 32'(sense_sel), 32'h0);
    chk("irq_masked", 32'(irq), 32'h0);
    apb(1'b1, 12'hCB0, 32'h04);
    repeat (4) @(posedge clk_sys);
    apb(1'b0, 12'hD00, 32'h0);
    chk("detect", rd & 32'h3, 32'(ev));
    apb(1'b1, 12'hD00, 32'h1F);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #1000000;
    n_errors++;
    finish_test;
  end

  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sense_mv = 13'h0;
    clr = 1'b1;
    n_errors = 0;
    check_count = 0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset_value", rd, rv[i]);
    end
    apb(1'b1, 12'h024, 32'hFF);
    apb(1'b0, 12'h024, 32'h0);
    chk("ovt_spare", rd, 32'h3F);
    apb(1'b1, 12'h030, 32'hA5);
    apb(1'b0, 12'h030, 32'h0);
    chk("excl_upper", rd, 32'hA5);
    apb(1'b1, 12'h034, 32'h5A);
    apb(1'b0, 12'h034, 32'h0);
    chk("excl_lower", rd, 32'h5A);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped_err", 32'(er), 32'h1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b0, 12'h025, 32'h0);
    chk("misaligned_err", 32'(er), 32'h1);
    // locked on channel 16, start bit self-clears
    apb(1'b1, 12'hCB0, 32'h7F);
    repeat (3) @(posedge clk_sys);
    chk("lock_ch16", 32'(sense_sel), 32'hF);
    apb(1'b0, 12'hCB0, 32'h0);
    chk("ctrl_readback", rd, 32'h7B);
    apb(1'b0, 12'hD00, 32'h0);
    chk("start_seen", rd & 32'h10, 32'h10);
    apb(1'b1, 12'hD00, 32'h1F);
    apb(1'b1, 12'h034, 32'h00);
    for (int i = 0; i < 10; i++)
    begin
      run(oc[i], 6'h00, ov_mv(oc[i]), 2'b00);
      run(oc[i], 6'h00, ov_mv(oc[i]) + 13'h1, 2'b01);
    end
    for (int i = 0; i < 5; i++)
    begin
      run(6'h2E, uc[i], uv_mv(uc[i]), 2'b00);
      run(6'h2E, uc[i], uv_mv(uc[i]) - 13'h1, 2'b10);
    end
    // new code without restart keeps the old one
    apb(1'b1, 12'h024, 32'h02);
    sense_mv <= 13'hBB8;
    apb(1'b1, 12'hCB0, 32'h07);
    apb(1'b1, 12'h024, 32'h2E);
    apb(1'b1, 12'hD00, 32'h1F);
    repeat (4 * DW + 4) @(posedge clk_sys);
    apb(1'b0, 12'hD00, 32'h0);
    chk("old_code_kept", rd & 32'h1, 32'h1);
    // round robin with every channel excluded, then only channel 5 checked
    apb(1'b1, 12'h028, 32'h26);
    apb(1'b1, 12'h030, 32'hFF);
    apb(1'b1, 12'h034, 32'hFF);
    apb(1'b1, 12'hD04, 32'h03);
    sense_mv <= 13'h3E8;
    apb(1'b1, 12'hCB0, 32'h05);
    apb(1'b1, 12'hD00, 32'h1F);
    clr <= 1'b0;
    repeat (17 * DW + 4) @(posedge clk_sys);
    chk("all_channels", 32'(seen), 32'hFFFF);
    // clock enable low freezes the scan
    ce <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd = 32'(sense_sel);
    repeat (8) @(posedge clk_sys);
    chk("ce_freeze", 32'(sense_sel), rd);
    ce <= 1'b1;
    chk("irq_quiet", 32'(irq), 32'h0);
    apb(1'b0, 12'hD00, 32'h0);
    chk("excluded", rd & 32'h3, 32'h0);
    apb(1'b1, 12'h034, 32'hEF);
    apb(1'b1, 12'hCB0, 32'h05);
    repeat (17 * DW + 4) @(posedge clk_sys);
    chk("irq_raised", 32'(irq), 32'h1);
    apb(1'b1, 12'hCB0, 32'h04);
    repeat (4) @(posedge clk_sys);
    apb(1'b0, 12'hD00, 32'h0);
    chk("included", rd & 32'h3, 32'h2);
    apb(1'b0, 12'hD08, 32'h0);
    chk("hit_channel", (rd >> 4) & 32'hF, 32'h4);
    apb(1'b1, 12'hD00, 32'h1F);
    repeat (3) @(posedge clk_sys);
    chk("irq_cleared", 32'(irq), 32'h0);
    repeat (4 * DW) @(posedge clk_sys);
    apb(1'b0, 12'hD00, 32'h0);
    chk("idle_quiet", rd & 32'h3, 32'h0);
    // self-test cycle
    apb(1'b1, 12'hCB0, 32'h06);
    repeat (8 * DW + 10) @(posedge clk_sys);
    apb(1'b0, 12'hD00, 32'h0);
    chk("self_test", rd & 32'h1C, 32'h14);
    finish_test;
  end
endmodule : tb
`default_nettype wire
